// *** hdl/mar_ack_retry.sv ***
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module mar_ack_retry
  import mar_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic [AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output mar_tx_req_t TX_REQ_O,
  input wire logic TX_DONE_I,
  input wire logic [7:0] TX_SEQ_I,
  input wire mar_rx_ack_t RX_ACK_I,
  input wire mar_rx_frame_t RX_FRAME_I,
  input wire logic BEACON_EN_I,
  input wire logic IN_CAP_I,
  input wire logic BACKOFF_BOUNDARY_I,
  output mar_ack_out_t ACK_O
);

  typedef enum logic [1:0] {O_IDLE = 2'b00, O_SEND = 2'b01, O_WAIT = 2'b10} mar_orig_st_t;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_TURN = 2'b01, R_ALIGN = 2'b10} mar_recp_st_t;

  logic [7:0] receive_mac_control_r, acktm_r, normal_tx_control_r, g1con_r, g2con_r, tx_pending_control_r;
  logic [7:0] tx_result_status_r, tx_turnaround_timing_r, tx_stabilize_timing_r;
  logic [2:0] evt_r;
  logic aw_full_r, w_full_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [AW-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstb_r;

  // Write channel handshakes; address and data accepted in either order
  wire aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire w_take = S_AXI_WVALID_I & S_AXI_WREADY_O;
  wire wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
  wire w_full_nxt = (w_full_r | w_take) & ~wr_fire;
  wire [7:0] wr_idx = 8'(awaddr_r[AW-1:2]);
  wire wr_en = wr_fire & wstb_r;
  wire wr_receive_mac_control = wr_en & (wr_idx == IDX_RX_MAC_CTRL);
  wire wr_acktm = wr_en & (wr_idx == IDX_ACK_TMOUT);
  wire wr_normal_tx_control = wr_en & (wr_idx == IDX_NORM_TX_CTRL);
  wire wr_g1con = wr_en & (wr_idx == IDX_SLOT1_TX_CTRL);
  wire wr_g2con = wr_en & (wr_idx == IDX_SLOT2_TX_CTRL);
  wire wr_tx_pending_control = wr_en & (wr_idx == IDX_TX_PEND_CTRL);
  wire wr_tx_turnaround_timing = wr_en & (wr_idx == IDX_TX_TURN);
  wire wr_tx_stabilize_timing = wr_en & (wr_idx == IDX_TX_STAB);
  wire wr_evt = wr_en & (wr_idx == IDX_TX_EVENT);
  wire wr_hit = (wr_idx == IDX_RX_MAC_CTRL) | (wr_idx == IDX_ACK_TMOUT) |
                (wr_idx == IDX_NORM_TX_CTRL) | (wr_idx == IDX_SLOT1_TX_CTRL) |
                (wr_idx == IDX_SLOT2_TX_CTRL) | (wr_idx == IDX_TX_PEND_CTRL) |
                (wr_idx == IDX_TX_RESULT) | (wr_idx == IDX_TX_TURN) |
                (wr_idx == IDX_TX_STAB) | (wr_idx == IDX_TX_EVENT);

  // Read decode; unmapped addresses answer SLVERR with zero data
  wire ar_take = S_AXI_ARVALID_I & arready_r;
  wire [7:0] rd_idx = 8'(S_AXI_ARADDR_I[AW-1:2]);
  logic [7:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_RX_MAC_CTRL: rd_val = receive_mac_control_r;
      IDX_ACK_TMOUT: rd_val = acktm_r;
      IDX_NORM_TX_CTRL: rd_val = normal_tx_control_r;
      IDX_SLOT1_TX_CTRL: rd_val = g1con_r;
      IDX_SLOT2_TX_CTRL: rd_val = g2con_r;
      IDX_TX_PEND_CTRL: rd_val = tx_pending_control_r;
      IDX_TX_RESULT: rd_val = tx_result_status_r;
      IDX_TX_TURN: rd_val = {tx_turnaround_timing_r[7:4], 4'h0};
      IDX_TX_STAB: rd_val = tx_stabilize_timing_r;
      IDX_TX_EVENT: rd_val = {5'h00, evt_r};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Bus slave state
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wstb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      S_AXI_AWREADY_O <= ~aw_full_nxt;
      S_AXI_WREADY_O <= ~w_full_nxt;
      if (aw_take) begin
        awaddr_r <= S_AXI_AWADDR_I;
      end
      if (w_take) begin
        wdata_r <= S_AXI_WDATA_I[7:0];
        wstb_r <= S_AXI_WSTRB_I[0];
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_val};
        rresp_r <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid_r & S_AXI_RREADY_I) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end

  assign S_AXI_BVALID_O = bvalid_r;
  assign S_AXI_BRESP_O = bresp_r;
  assign S_AXI_ARREADY_O = arready_r;
  assign S_AXI_RVALID_O = rvalid_r;
  assign S_AXI_RDATA_O = rdata_r;
  assign S_AXI_RRESP_O = rresp_r;

  // Originator: buffer choice, normal buffer first
  mar_orig_st_t ost_r, ost_nxt;
  logic [1:0] obuf_r, obuf_nxt, otry_r, otry_nxt;
  logic [7:0] oseq_r, oseq_nxt;
  logic [6:0] osym_r, osym_nxt;
  logic [8:0] opre_r, opre_nxt;
  logic fin, fin_fail, take;
  wire trig_n = normal_tx_control_r[TRIG_BIT];
  wire trig_1 = g1con_r[TRIG_BIT];
  wire trig_2 = g2con_r[TRIG_BIT];
  wire [1:0] pick = trig_n ? BUF_NORM : (trig_1 ? BUF_SLOT1 : BUF_SLOT2);
  wire any_trig = trig_n | trig_1 | trig_2;
  wire [7:0] sel_con = (obuf_r == BUF_NORM) ? normal_tx_control_r :
                       ((obuf_r == BUF_SLOT1) ? g1con_r : g2con_r);
  wire sel_ackreq = sel_con[ACK_REQ_BIT];
  wire sel_direct = (obuf_r != BUF_NORM) | ~normal_tx_control_r[INDIRECT_BIT];
  wire [6:0] ack_wait = acktm_r[6:0];
  wire osym_tick = (opre_r == SYM_CYC_LAST);
  wire ack_match = RX_ACK_I.valid & (RX_ACK_I.seq == oseq_r);
  wire ack_late = (osym_r >= ack_wait);
  wire [1:0] retries = 2'(otry_r - 2'h1);

  // Originator next state
  always_comb begin
    ost_nxt = ost_r;
    obuf_nxt = obuf_r;
    otry_nxt = otry_r;
    oseq_nxt = oseq_r;
    osym_nxt = osym_r;
    opre_nxt = osym_tick ? 9'h000 : 9'(opre_r + 9'h001);
    fin = 1'b0;
    fin_fail = 1'b0;
    take = 1'b0;
    unique case (ost_r)
      O_IDLE: begin
        if (any_trig) begin
          take = 1'b1;
          obuf_nxt = pick;
          otry_nxt = 2'h1;
          ost_nxt = O_SEND;
        end
      end
      O_SEND: begin
        if (TX_DONE_I) begin
          oseq_nxt = TX_SEQ_I;
          osym_nxt = 7'h00;
          opre_nxt = 9'h000;
          if (sel_ackreq) begin
            ost_nxt = O_WAIT;
          end else begin
            fin = 1'b1;
            ost_nxt = O_IDLE;
          end
        end
      end
      O_WAIT: begin
        if (osym_tick) begin
          osym_nxt = 7'(osym_r + 7'h01);
        end
        if (ack_match) begin
          fin = 1'b1;
          ost_nxt = O_IDLE;
        end else if (ack_late) begin
          if ((otry_r < MAX_FRAME_TRIES) & sel_direct) begin
            otry_nxt = 2'(otry_r + 2'h1);
            ost_nxt = O_SEND;
          end else begin
            fin = 1'b1;
            fin_fail = 1'b1;
            ost_nxt = O_IDLE;
          end
        end
      end
      default: ost_nxt = O_IDLE;
    endcase
  end

  // Originator registers and request to the radio
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ost_r <= O_IDLE;
      obuf_r <= BUF_NORM;
      otry_r <= 2'h0;
      oseq_r <= 8'h00;
      osym_r <= 7'h00;
      opre_r <= 9'h000;
      TX_REQ_O <= '0;
    end else begin
      ost_r <= ost_nxt;
      obuf_r <= obuf_nxt;
      otry_r <= otry_nxt;
      oseq_r <= oseq_nxt;
      osym_r <= osym_nxt;
      opre_r <= opre_nxt;
      TX_REQ_O.req <= (ost_nxt == O_SEND);
      TX_REQ_O.buf_sel <= obuf_nxt;
      TX_REQ_O.resend <= (otry_nxt > 2'h1);
    end
  end

  // Recipient: automatic acknowledgment timing
  mar_recp_st_t rst_r, rst_nxt;
  logic [8:0] rpre_r, rpre_nxt;
  logic [4:0] rsym_r, rsym_nxt;
  logic [7:0] rseq_r, rseq_nxt;
  logic rpend_r, rpend_nxt, ack_go;
  wire [4:0] turn_time = 5'(tx_turnaround_timing_r[7:4]) + 5'(tx_stabilize_timing_r[7:4]);
  wire rsym_tick = (rpre_r == SYM_CYC_LAST);
  wire in_cap = BEACON_EN_I & IN_CAP_I;
  wire auto_ack_disable = receive_mac_control_r[AUTO_ACK_DIS_BIT];
  wire data_request_pending_flag = acktm_r[DRQ_PEND_BIT];
  wire ack_due = RX_FRAME_I.frame_end & RX_FRAME_I.ack_req & ~auto_ack_disable;

  // Recipient next state
  always_comb begin
    rst_nxt = rst_r;
    rsym_nxt = rsym_r;
    rseq_nxt = rseq_r;
    rpend_nxt = rpend_r;
    rpre_nxt = rsym_tick ? 9'h000 : 9'(rpre_r + 9'h001);
    ack_go = 1'b0;
    unique case (rst_r)
      R_IDLE: begin
        if (ack_due) begin
          rst_nxt = R_TURN;
          rsym_nxt = 5'h00;
          rpre_nxt = 9'h001;
          rseq_nxt = RX_FRAME_I.seq;
          rpend_nxt = data_request_pending_flag & RX_FRAME_I.data_req;
        end
      end
      R_TURN: begin
        if (rsym_tick) begin
          rsym_nxt = 5'(rsym_r + 5'h01);
        end
        if (rsym_r >= turn_time) begin
          if (in_cap) begin
            rst_nxt = R_ALIGN;
          end else begin
            ack_go = 1'b1;
            rst_nxt = R_IDLE;
          end
        end
      end
      R_ALIGN: begin
        if (BACKOFF_BOUNDARY_I) begin
          ack_go = 1'b1;
          rst_nxt = R_IDLE;
        end
      end
      default: rst_nxt = R_IDLE;
    endcase
  end

  // Recipient registers; ack is started without channel check
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_r <= R_IDLE;
      rpre_r <= 9'h000;
      rsym_r <= 5'h00;
      rseq_r <= 8'h00;
      rpend_r <= 1'b0;
      ACK_O <= '0;
    end else begin
      rst_r <= rst_nxt;
      rpre_r <= rpre_nxt;
      rsym_r <= rsym_nxt;
      rseq_r <= rseq_nxt;
      rpend_r <= rpend_nxt;
      ACK_O.start <= ack_go;
      ACK_O.pend <= rpend_r;
      ACK_O.seq <= rseq_r;
    end
  end

  // Completion effects per buffer
  wire fin_n = fin & (obuf_r == BUF_NORM);
  wire fin_1 = fin & (obuf_r == BUF_SLOT1);
  wire fin_2 = fin & (obuf_r == BUF_SLOT2);
  wire take_n = take & (pick == BUF_NORM);
  wire take_1 = take & (pick == BUF_SLOT1);
  wire take_2 = take & (pick == BUF_SLOT2);
  wire fp_cap = (ost_r == O_WAIT) & ack_match & (obuf_r == BUF_NORM);

  // Control and status registers
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      receive_mac_control_r <= RX_MAC_CTRL_RST;
      acktm_r <= ACK_TMOUT_RST;
      normal_tx_control_r <= 8'h00;
      g1con_r <= 8'h00;
      g2con_r <= 8'h00;
      tx_pending_control_r <= 8'h00;
      tx_result_status_r <= 8'h00;
      tx_turnaround_timing_r <= TX_TURN_RST;
      tx_stabilize_timing_r <= TX_STAB_RST;
      evt_r <= 3'h0;
    end else begin
      if (wr_receive_mac_control) receive_mac_control_r <= wdata_r;
      if (wr_acktm) acktm_r <= wdata_r;
      if (wr_tx_pending_control) tx_pending_control_r <= wdata_r;
      if (wr_tx_turnaround_timing) tx_turnaround_timing_r <= {wdata_r[7:4], 4'h0};
      if (wr_tx_stabilize_timing) tx_stabilize_timing_r <= tx_stabilize_timing_r ^ (tx_stabilize_timing_r ^ wdata_r);
      // Normal control: trigger clears when taken, status bit from ack
      if (wr_normal_tx_control) begin
        normal_tx_control_r[3:0] <= wdata_r[3:0];
      end else if (take_n) begin
        normal_tx_control_r[TRIG_BIT] <= 1'b0;
      end
      if (fp_cap) normal_tx_control_r[RX_PEND_STAT_BIT] <= RX_ACK_I.pend;
      // Slot controls: hardware retry report wins over software write
      if (wr_g1con) begin
        g1con_r <= wdata_r;
      end else if (take_1) begin
        g1con_r[TRIG_BIT] <= 1'b0;
      end
      if (fin_1) g1con_r[RETRY_LSB +: 2] <= retries;
      if (wr_g2con) begin
        g2con_r <= wdata_r;
      end else if (take_2) begin
        g2con_r[TRIG_BIT] <= 1'b0;
      end
      if (fin_2) g2con_r[RETRY_LSB +: 2] <= retries;
      // Result status
      if (fin_n) begin
        tx_result_status_r[NORM_FAIL_BIT] <= fin_fail;
        tx_result_status_r[RETRY_LSB +: 2] <= retries;
      end
      if (fin_1) tx_result_status_r[1] <= fin_fail;
      if (fin_2) tx_result_status_r[2] <= fin_fail;
      // Done flags: write one clears, a new completion wins
      evt_r <= (evt_r & ~(wr_evt ? wdata_r[2:0] : 3'h0)) | {fin_2, fin_1, fin_n};
    end
  end

endmodule // mar_ack_retry
`default_nettype wire

// *** hdl/mar_pkg.sv ***
`default_nettype none
package mar_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RX_MAC_CTRL = 8'h00;
  localparam logic [7:0] IDX_ACK_TMOUT = 8'h12;
  localparam logic [7:0] IDX_NORM_TX_CTRL = 8'h1B;
  localparam logic [7:0] IDX_SLOT1_TX_CTRL = 8'h1C;
  localparam logic [7:0] IDX_SLOT2_TX_CTRL = 8'h1D;
  localparam logic [7:0] IDX_TX_PEND_CTRL = 8'h21;
  localparam logic [7:0] IDX_TX_RESULT = 8'h24;
  localparam logic [7:0] IDX_TX_TURN = 8'h27;
  localparam logic [7:0] IDX_TX_STAB = 8'h2E;
  localparam logic [7:0] IDX_TX_EVENT = 8'h31;

  // Field positions
  localparam int AUTO_ACK_DIS_BIT = 5;
  localparam int DRQ_PEND_BIT = 7;
  localparam int TRIG_BIT = 0;
  localparam int ACK_REQ_BIT = 2;
  localparam int INDIRECT_BIT = 3;
  localparam int RX_PEND_STAT_BIT = 4;
  localparam int RETRY_LSB = 6;
  localparam int NORM_FAIL_BIT = 0;
  localparam int NORM_DONE_BIT = 0;

  // Values after reset
  localparam logic [7:0] RX_MAC_CTRL_RST = 8'h00;
  localparam logic [7:0] ACK_TMOUT_RST = 8'h36;
  localparam logic [7:0] TX_TURN_RST = 8'h80;
  localparam logic [7:0] TX_STAB_RST = 8'h40;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYMBOL_NS = 16000;
  localparam int SYM_CYC = SYMBOL_NS / CLK_PERIOD_NS;
  localparam logic [8:0] SYM_CYC_LAST = 9'(SYM_CYC - 1);
  localparam logic [1:0] MAX_FRAME_TRIES = 2'h3;

  // Buffer selectors
  localparam logic [1:0] BUF_NORM = 2'h0;
  localparam logic [1:0] BUF_SLOT1 = 2'h1;
  localparam logic [1:0] BUF_SLOT2 = 2'h2;

  // Transmit request to the radio sequencer
  typedef struct packed {
    logic req;
    logic [1:0] buf_sel;
    logic resend;
  } mar_tx_req_t;

  // End of a received frame
  typedef struct packed {
    logic frame_end;
    logic ack_req;
    logic data_req;
    logic [7:0] seq;
  } mar_rx_frame_t;

  // Received acknowledgment
  typedef struct packed {
    logic valid;
    logic pend;
    logic [7:0] seq;
  } mar_rx_ack_t;

  // Acknowledgment to send
  typedef struct packed {
    logic start;
    logic pend;
    logic [7:0] seq;
  } mar_ack_out_t;

endpackage
`default_nettype wire

// *** sim/mar_ack_retry_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module mar_ack_retry_bench import mar_pkg::*;;
  typedef struct packed {logic [1:0] on; logic [7:0] stat; logic [1:0] tries; logic [7:0] ctl;} mar_row_t;
  mar_row_t rows [4] = '{'{2'h1, 8'h00, 2'h1, 8'h14}, '{2'h2, 8'h40, 2'h2, 8'h04},
    '{2'h3, 8'h80, 2'h3, 8'h14}, '{2'h0, 8'h81, 2'h3, 8'h14}};
  logic [7:0] rst_idx [7] = '{8'h00, 8'h12, 8'h1B, 8'h1C, 8'h24, 8'h27, 8'h2E};
  logic [7:0] rst_val [7] = '{8'h00, 8'h36, 8'h00, 8'h00, 8'h00, 8'h80, 8'h40};
  logic clk = 1'b0;
  logic rst_n, awvalid, wvalid, arvalid, rready, beacon, in_cap, bnd;
  logic awready, wready, bvalid, arready, rvalid, txdone;
  logic [7:0] awaddr, araddr, txseq, seqc;
  logic [7:0] bcnt = 8'h00;
  logic [31:0] wdata, rdata, rdat;
  logic [1:0] bresp, rresp, rrsp, wrsp, ack_on, tries;
  mar_tx_req_t txreq;
  mar_rx_ack_t rxack;
  mar_rx_frame_t rxf;
  mar_ack_out_t ack;
  int n_errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  // Backoff slot starts every 160 cycles
  always @(posedge clk) begin
    bcnt <= (bcnt == 8'h9F) ? 8'h00 : bcnt + 8'h01;
    bnd <= (bcnt == 8'h00);
  end
  mar_ack_retry mar_ack_retry_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TX_REQ_O(txreq), .TX_DONE_I(txdone),
    .TX_SEQ_I(txseq), .RX_ACK_I(rxack), .RX_FRAME_I(rxf), .BEACON_EN_I(beacon),
    .IN_CAP_I(in_cap), .BACKOFF_BOUNDARY_I(bnd), .ACK_O(ack));
  mar_radio_model mar_radio_model_inst (.clk_i(clk), .rst_n_i(rst_n), .tx_req_i(txreq),
    .ack_on_i(ack_on), .tx_done_o(txdone), .tx_seq_o(txseq), .rx_ack_o(rxack), .tries_o(tries));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Bus write: address and data together, each released when taken
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic a, w;
    @(posedge clk);
    a = 1'b1;
    w = 1'b1;
    awaddr <= {i[5:0], 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (a || w) begin
      @(posedge clk);
      if (a && awready) awvalid <= 1'b0;
      if (a && awready) a = 1'b0;
      if (w && wready) wvalid <= 1'b0;
      if (w && wready) w = 1'b0;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    wrsp = bresp;
  endtask
  // Bus read; ready is raised only once the answer is seen
  task automatic rd(input logic [7:0] i);
    @(posedge clk);
    araddr <= {i[5:0], 2'h0};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic evwait(input int b);
    do rd(IDX_TX_EVENT); while (rdat[b] !== 1'b1);
    wr(IDX_TX_EVENT, 8'h07);
  endtask
  // One received frame; measures cycles to the ack start
  task automatic ackcase(input logic dq, aq, input int lo, hi, input logic pd);
    int n;
    n = 0;
    seqc = seqc + 8'h11;
    @(posedge clk);
    rxf <= '{1'b1, aq, dq, seqc};
    @(posedge clk);
    rxf <= '{1'b0, ~aq, ~dq, ~seqc};
    while (n < 1000 && ack.start !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    if (n == 1000) n = 0;
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    if (n != 0) chk({23'h0, ack.pend, ack.seq}, {23'h0, pd, seqc});
    $display("Test ack case done after %0d cycles", n);
  endtask
  initial begin
    {rst_n, awvalid, wvalid, arvalid, rready, beacon, in_cap} = 7'h00;
    {awaddr, araddr, wdata, seqc, ack_on, rxf} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rst_idx[k]) begin
      rd(rst_idx[k]);
      chk(rdat, {24'h0, rst_val[k]});
    end
    wr(IDX_TX_RESULT, 8'hFF);
    chk({30'h0, wrsp}, 32'h0);
    rd(IDX_TX_RESULT);
    chk(rdat, 32'h0);
    wr(IDX_SLOT1_TX_CTRL, 8'hC8);
    rd(IDX_SLOT1_TX_CTRL);
    chk(rdat, 32'hC8);
    rd(8'h05);
    chk({rdat[29:0], rrsp}, 32'h2);
    wr(8'h05, 8'h00);
    chk({30'h0, wrsp}, 32'h2);
    wr(IDX_ACK_TMOUT, 8'h01);
    $display("Test registers done");
    foreach (rows[k]) begin
      ack_on <= rows[k].on;
      wr(IDX_NORM_TX_CTRL, 8'h05);
      evwait(NORM_DONE_BIT);
      rd(IDX_TX_RESULT);
      chk(rdat, {24'h0, rows[k].stat});
      chk({30'h0, tries}, {30'h0, rows[k].tries});
      rd(IDX_NORM_TX_CTRL);
      chk(rdat, {24'h0, rows[k].ctl});
      $display("Test normal row %0d done", k);
    end
    ack_on <= 2'h0;
    wr(IDX_SLOT1_TX_CTRL, 8'h01);
    evwait(1);
    chk({30'h0, tries}, 32'h1);
    wr(IDX_SLOT2_TX_CTRL, 8'h05);
    evwait(2);
    chk({30'h0, tries}, 32'h3);
    rd(IDX_TX_RESULT);
    chk(rdat & 32'h06, 32'h04);
    rd(IDX_SLOT2_TX_CTRL);
    chk(rdat, 32'h84);
    wr(IDX_NORM_TX_CTRL, 8'h0D);
    evwait(0);
    rd(IDX_TX_RESULT);
    chk({rdat[29:0] & 30'hC1, tries}, 32'h5);
    $display("Test slots and indirect done");
    wr(IDX_TX_TURN, 8'h10);
    wr(IDX_TX_STAB, 8'h10);
    wr(IDX_ACK_TMOUT, 8'h81);
    ackcase(1'b1, 1'b1, 801, 801, 1'b1);
    ackcase(1'b0, 1'b1, 801, 801, 1'b0);
    ackcase(1'b1, 1'b0, 0, 0, 1'b0);
    beacon <= 1'b1;
    in_cap <= 1'b1;
    ackcase(1'b1, 1'b1, 801, 962, 1'b1);
    wr(IDX_RX_MAC_CTRL, 8'h20);
    ackcase(1'b1, 1'b1, 0, 0, 1'b0);
    conclude();
  end
  // Cuts a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule // mar_ack_retry_bench
bind mar_ack_retry mar_ack_retry_checker mar_ack_retry_checker_inst (.CLK_SYS_I(CLK_SYS_I),
  .RST_N_I(RST_N_I), .TX_REQ_O(TX_REQ_O), .TX_DONE_I(TX_DONE_I), .ACK_O(ACK_O),
  .RX_FRAME_I(RX_FRAME_I), .BEACON_EN_I(BEACON_EN_I), .IN_CAP_I(IN_CAP_I),
  .BACKOFF_BOUNDARY_I(BACKOFF_BOUNDARY_I), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .S_AXI_RDATA_O(S_AXI_RDATA_O));
`default_nettype wire

// *** sim/mar_ack_retry_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// Watches the transmit, acknowledgment and read ports
module mar_ack_retry_checker
  import mar_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire mar_tx_req_t TX_REQ_O,
  input wire logic TX_DONE_I,
  input wire mar_ack_out_t ACK_O,
  input wire mar_rx_frame_t RX_FRAME_I,
  input wire logic BEACON_EN_I,
  input wire logic IN_CAP_I,
  input wire logic BACKOFF_BOUNDARY_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O
);
  logic sched_r, dreq_r;
  logic [7:0] seq_r;
  logic [1:0] tries_r;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // Last frame that asked for an ack, and resends of the current frame
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sched_r <= 1'b0;
      dreq_r <= 1'b0;
      seq_r <= 8'h00;
      tries_r <= 2'h0;
    end else begin
      if (RX_FRAME_I.frame_end && RX_FRAME_I.ack_req) begin
        sched_r <= 1'b1;
        dreq_r <= RX_FRAME_I.data_req;
        seq_r <= RX_FRAME_I.seq;
      end else if (ACK_O.start) begin
        sched_r <= 1'b0;
      end
      if ($rose(TX_REQ_O.req)) begin
        tries_r <= TX_REQ_O.resend ? tries_r + 2'h1 : 2'h0;
      end
    end
  end
  chk_req_hold: assert property (TX_REQ_O.req && !TX_DONE_I |=>
    TX_REQ_O.req && $stable(TX_REQ_O.buf_sel)) else $error("Request dropped before done");
  chk_req_gap: assert property (TX_DONE_I && TX_REQ_O.req |=>
    !(TX_REQ_O.req && TX_REQ_O.resend) [*8]) else $error("Resend came without an ack wait");
  chk_try_limit: assert property ($rose(TX_REQ_O.req) && TX_REQ_O.resend |-> tries_r < 2'h2)
    else $error("More than three transmissions");
  chk_ack_pulse: assert property (ACK_O.start |=> !ACK_O.start)
    else $error("Ack start longer than one cycle");
  chk_ack_cause: assert property (ACK_O.start |-> sched_r && ACK_O.seq == seq_r)
    else $error("Ack without matching frame");
  chk_ack_pend: assert property (ACK_O.start && ACK_O.pend |-> dreq_r)
    else $error("Frame pending set outside data request");
  chk_cap_slot: assert property (ACK_O.start && BEACON_EN_I && IN_CAP_I |->
    $past(BACKOFF_BOUNDARY_I)) else $error("Ack off a backoff boundary");
  chk_read_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("Read answer not held");
  cov_cap_ack: cover property (ACK_O.start && IN_CAP_I);
  cov_resend: cover property ($rose(TX_REQ_O.req) && TX_REQ_O.resend);
  cov_read_stall: cover property (S_AXI_RVALID_O && !S_AXI_RREADY_I);
endmodule // mar_ack_retry_checker
`default_nettype wire

// *** sim/mar_radio_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Radio and remote node: sends each frame, then answers with an ack
module mar_radio_model
  import mar_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire mar_tx_req_t tx_req_i,
  input wire logic [1:0] ack_on_i,
  output logic tx_done_o,
  output logic [7:0] tx_seq_o,
  output mar_rx_ack_t rx_ack_o,
  output logic [1:0] tries_o
);
  localparam logic [7:0] SEQ_C = 8'h3C;
  logic busy_r;
  logic [5:0] cnt_r;
  // Idle lines toggle so a stale value never passes for a live one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      cnt_r <= 6'h00;
      tries_o <= 2'h0;
      tx_done_o <= 1'b0;
      tx_seq_o <= 8'h00;
      rx_ack_o <= '0;
    end else begin
      tx_done_o <= 1'b0;
      tx_seq_o <= ~tx_seq_o;
      rx_ack_o <= '{1'b0, ~rx_ack_o.pend, ~rx_ack_o.seq};
      cnt_r <= cnt_r + 6'h01;
      if (!busy_r && tx_req_i.req) begin
        busy_r <= 1'b1;
        cnt_r <= 6'h00;
        tries_o <= tx_req_i.resend ? tries_o + 2'h1 : 2'h1;
      end
      if (busy_r && cnt_r == 6'h08) begin
        tx_done_o <= 1'b1;
        tx_seq_o <= SEQ_C;
      end
      // Matching ack on the chosen try, a foreign sequence otherwise
      if (busy_r && cnt_r == 6'h1E) begin
        busy_r <= 1'b0;
        rx_ack_o <= '{1'b1, tries_o[0], (tries_o == ack_on_i) ? SEQ_C : SEQ_C + 8'h01};
      end
    end
  end
endmodule // mar_radio_model
`default_nettype wire
